// ### pc_stack_indirect_addr.sv
/*
  Program counter, return stack, paging and indirect addressing of a small
  8-bit core. Assumes the decoder gives one operation per cycle and the
  register file answers reads combinationally.
*/
// Functional notes
// (RQ1) 13-bit counter, low byte readable and writable
// (RQ2) upper bits change only from holding latch; the code also sets them on steps, jumps, returns and interrupts
// (RQ3) eight-entry 13-bit stack, pointer hidden
// (RQ4) push counter on call or interrupt
// (RQ5) pop counter on any return
// (RQ6) push and pop keep holding latch
// (RQ7) stack wraps, oldest entry overwritten
// (RQ8) jump takes 11 bits plus latch bit 3; the code takes latch bits 4:3
// (RQ9) full counter saved, returns restore all
// (RQ10) software sets page bit before jumping
// (RQ11) indirect port redirects to pointer address
// (RQ12) self-indirect read returns zero
// (RQ13) self-indirect write changes nothing
// (RQ14) effective address is bank bit and pointer
// (RQ15) low byte write loads upper bits too
// (RQ16) reset clears program counter
`timescale 1ns/10ps
module pc_stack_indirect_addr
  import pcseq_pkg::*;
#(
  parameter logic [PC_W-1:0] INTR_VECTOR = 13'h0004
) (
  // clock and reset
  input  wire logic                      core_clk_i,
  input  wire logic                      rst_i,

  // decoder operation
  input  wire pcseq_pkg::pc_op_t         pc_op_i,
  input  wire logic [JUMP_ADDR_W-1:0]    jump_addr_i,
  input  wire logic [DATA_W-1:0]         pc_low_wr_data_i,

  // holding latch and bank bit from the register file
  input  wire logic [DATA_W-1:0]         pc_high_holding_latch_i,
  input  wire logic                      indirect_bank_select_i,

  // indirect access
  input  wire logic [DATA_W-1:0]         indirect_pointer_i,
  input  wire logic                      indirect_rd_i,
  input  wire logic                      indirect_wr_i,
  input  wire logic [DATA_W-1:0]         indirect_wr_data_i,
  input  wire logic [DATA_W-1:0]         rf_rd_data_i,

  // fetch address and visible low byte
  output logic      [PC_W-1:0]           fetch_addr_o,
  output logic      [DATA_W-1:0]         pc_low_byte_o,

  // register file side of indirect access
  output logic      [EFF_ADDR_W-1:0]     rf_addr_o,
  output logic                           rf_rd_o,
  output logic                           rf_wr_o,
  output logic      [DATA_W-1:0]         rf_wr_data_o,
  output logic      [DATA_W-1:0]         indirect_data_port_o
);
  // ----------------------------------------
  // elaboration checks
  // ----------------------------------------
  // jumps fill the counter with the jump field plus page field latch bits above it
  localparam int PAGE_FIELD_W = PC_W - JUMP_ADDR_W;

  if (PC_LO_W + PC_HI_W != PC_W) begin
    $error("low byte and upper bits must cover the counter");
  end

  if (PAGE_FIELD_W < 1) begin
    $error("jump field leaves no room for a page bit");
  end

  // the page bits must come from latch bits that also feed the upper bits
  if (PAGE_BIT_POS + PAGE_FIELD_W > PC_HI_W) begin
    $error("page bits must lie inside the latch bits that feed the counter");
  end

  // a low byte write takes the whole write data word
  if (PC_LO_W != DATA_W) begin
    $error("low byte must be as wide as the data word");
  end

  if (PC_HI_W > DATA_W) begin
    $error("upper bits must fit inside the holding latch");
  end

  if (EFF_ADDR_W != DATA_W + 1) begin
    $error("effective address is one bank bit above the pointer");
  end

  if (STACK_DEPTH < 2) begin
    $error("return stack needs at least two entries");
  end

  // ----------------------------------------
  // state record
  // ----------------------------------------
  typedef struct packed {
    logic [PC_W-1:0]   pc;
    logic [DATA_W-1:0] rd_data;
  } seq_state_t;

  seq_state_t      state_r;
  seq_state_t      state_nxt;
  logic            push;
  logic            pop;
  logic [PC_W-1:0] stack_top;
  logic [PC_W-1:0] pc_inc;
  logic            self_ref;

  logic            op_call;
  logic            op_intr;
  logic            op_ret;
  logic [PC_W-1:0] jump_target;
  logic [PC_W-1:0] low_wr_target;

  // ----------------------------------------
  // operation decode
  // ----------------------------------------
  assign op_call = (pc_op_i == PC_OP_CALL);
  assign op_intr = (pc_op_i == PC_OP_INTR);
  assign op_ret  = (pc_op_i == PC_OP_RETURN);

  // ----------------------------------------
  // return stack
  // ----------------------------------------
  // call and interrupt both save the address after the current one
  assign push = op_call || op_intr; // see (RQ4)
  assign pop  = op_ret; // see (RQ5)
  assign pc_inc = state_r.pc + PC_W'(1);

  return_stack #(
    .DEPTH (STACK_DEPTH),
    .WIDTH (PC_W)
  ) u_stack (
    .core_clk_i  (core_clk_i),
    .rst_i       (rst_i),
    .push_i      (push),
    .pop_i       (pop),
    .push_data_i (pc_inc),  // see (RQ9)
    .top_o       (stack_top)
  );

  // ----------------------------------------
  // indirect addressing
  // ----------------------------------------
  // bank bit is carried as the top bit of the nine-bit register file address
  assign rf_addr_o = {indirect_bank_select_i, indirect_pointer_i}; // see (RQ14)
  assign self_ref  = (indirect_pointer_i == INDIRECT_SELF);
  assign rf_rd_o   = indirect_rd_i && !self_ref; // see (RQ11)
  assign rf_wr_o   = indirect_wr_i && !self_ref; // see (RQ13)
  assign rf_wr_data_o = indirect_wr_data_i;

  // ----------------------------------------
  // branch targets
  // ----------------------------------------
  // jumps reach only within a page; the page comes from the latch, which
  // software must have set up before the jump (see RQ8) (see RQ2)
  assign jump_target   = {pc_high_holding_latch_i[PAGE_BIT_POS+PAGE_FIELD_W-1:PAGE_BIT_POS],
                          jump_addr_i};
  // a low byte write drags the upper bits in from the latch at once
  assign low_wr_target = {pc_high_holding_latch_i[PC_HI_W-1:0], pc_low_wr_data_i}; // see (RQ15)

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    state_nxt = state_r;
    // one source per cycle; the decoder never asks for two at once
    case (pc_op_i)
      PC_OP_STEP: begin
        state_nxt.pc = pc_inc;
      end
      PC_OP_CALL, PC_OP_JUMP: begin
        state_nxt.pc = jump_target; // see (RQ8) (see RQ2)
      end
      PC_OP_RETURN: begin
        // latch is an input only, so returns cannot disturb it (see RQ6)
        state_nxt.pc = stack_top; // see (RQ9)
      end
      PC_OP_INTR: begin
        // the stack saves the return address on this same edge
        state_nxt.pc = INTR_VECTOR;
      end
      PC_OP_WR_LOW: begin
        state_nxt.pc = low_wr_target; // see (RQ15) (see RQ1)
      end
      PC_OP_HOLD: begin
        // stalls keep the fetch address where it is
        state_nxt.pc = state_r.pc;
      end
      default: begin
        // an unused code behaves as a plain step
        state_nxt.pc = pc_inc;
      end
    endcase
    // read data stands until the next indirect read, so a late sample is safe
    if (indirect_rd_i) begin
      state_nxt.rd_data = self_ref ? SELF_READ_VAL : rf_rd_data_i; // see (RQ12)
    end
  end

  // ----------------------------------------
  // state register
  // ----------------------------------------
  // stack pointer lives in the stack module and resets with it
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_r.pc      <= PC_RESET; // see (RQ16)
      state_r.rd_data <= SELF_READ_VAL;
    end else begin
      state_r <= state_nxt;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  // all three come straight from flops
  assign fetch_addr_o         = state_r.pc;
  assign pc_low_byte_o        = state_r.pc[PC_LO_W-1:0]; // see (RQ1)
  assign indirect_data_port_o = state_r.rd_data;
endmodule

// ### pc_stack_indirect_addr_tb.sv
/* self-checking bench for pc_stack_indirect_addr
   assumes rf_model stands in for the register file */
`timescale 1ns/10ps
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin err_count++; \
  $display("unexpected %0t got %h want %h", $time, a, b); end end
module pc_stack_indirect_addr_tb;
  import pcseq_pkg::*;
  localparam logic [12:0] IV = 13'h0123;
  logic core_clk_i = 0, rst_i = 1, indirect_bank_select_i = 0;
  logic indirect_rd_i = 0, indirect_wr_i = 0, rf_rd_o, rf_wr_o;
  pc_op_t pc_op_i = PC_OP_HOLD;
  logic [10:0] jump_addr_i = 11'h000;
  logic [7:0] pc_low_wr_data_i = 8'h00, pc_high_holding_latch_i = 8'h00;
  logic [7:0] indirect_pointer_i = 8'h00, indirect_wr_data_i = 8'h00;
  logic [7:0] rf_rd_data_i, pc_low_byte_o, rf_wr_data_o, indirect_data_port_o, ram [512];
  logic [12:0] fetch_addr_o, pc, stk [8];
  logic [8:0] rf_addr_o;
  logic [2:0] sp;
  logic [21:0] q [$], pend [$], e;
  int seed = 17, err_count = 0, comparisons = 0;
  pc_stack_indirect_addr #(.INTR_VECTOR(IV)) dut (.*);
  rf_model rf (.core_clk_i, .addr_i(rf_addr_o), .rd_i(rf_rd_o), .wr_i(rf_wr_o),
    .wr_data_i(rf_wr_data_o), .rd_data_o(rf_rd_data_i));
  initial forever #5 core_clk_i = ~core_clk_i;
  task automatic step(pc_op_t o, logic rd);
    logic [7:0] l, d, p, v;
    logic [10:0] a;
    logic b;
    @(posedge core_clk_i);
    {l, d, p, a, b} = 36'({$random(seed), $random(seed)});
    p = p & 8'h07;
    pc_op_i <= o;
    {jump_addr_i, pc_low_wr_data_i, pc_high_holding_latch_i} <= {a, d, l};
    {indirect_pointer_i, indirect_bank_select_i, indirect_wr_data_i} <= {p, b, d};
    {indirect_rd_i, indirect_wr_i} <= {rd, !rd};
    v = (p == 8'h00) ? 8'h00 : ram[{b, p}];
    if (!rd && p != 8'h00) ram[{b, p}] = d;
    case (o)
      PC_OP_STEP: pc = pc + 13'h1;
      PC_OP_CALL, PC_OP_INTR: begin
        stk[sp] = pc + 13'h1;
        sp++;
        pc = (o == PC_OP_CALL) ? {l[4:3], a} : IV;
      end
      PC_OP_JUMP: pc = {l[4:3], a};
      PC_OP_RETURN: begin
        sp--;
        pc = stk[sp];
      end
      PC_OP_WR_LOW: pc = {l[4:0], d};
      default: ;
    endcase
    q.push_back({rd, v, pc});
  endtask
  task automatic do_rst();
    // mid-run: one idle cycle first, so the last operation is not repeated
    if (!rst_i) begin
      @(posedge core_clk_i);
      pc_op_i <= PC_OP_HOLD;
      {indirect_rd_i, indirect_wr_i} <= 2'b00;
      @(posedge core_clk_i);
      rst_i <= 1'b1;
    end
    repeat (16) @(posedge core_clk_i);
    rst_i <= 1'b0;
    pc = 13'h0000;
    sp = 3'h0;
    #1 `CHK(fetch_addr_o, 13'h0000)
    `CHK(indirect_data_port_o, 8'h00)
    $display("test reset done");
  endtask
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // --------
  // result watcher, one cycle behind the driver
  // --------
  always @(posedge core_clk_i) begin
    #1;
    while (pend.size() > 0) begin
      e = pend.pop_front();
      `CHK(fetch_addr_o, e[12:0])
      `CHK(pc_low_byte_o, e[7:0])
      if (e[21]) `CHK(indirect_data_port_o, e[20:13])
    end
    pend = q;
    q.delete();
  end
  initial begin
    #20000 err_count++;
    final_report();
  end
  initial begin
    for (int i = 0; i < 512; i++) ram[i] = 8'(i) ^ 8'hA5;
    do_rst();
    repeat (10) step(PC_OP_CALL, 1'b1);
    repeat (10) step(PC_OP_RETURN, 1'b1);
    $display("test stack wrap done");
    repeat (400) step(pc_op_t'($unsigned($random(seed)) % 7), 1'($random(seed)));
    $display("test random done");
    do_rst();
    repeat (20) step(pc_op_t'($unsigned($random(seed)) % 7), 1'b1);
    $display("test second reset done");
    final_report();
  end
endmodule

// ### pcseq_asserts.sv
/* checker on the ports of pc_stack_indirect_addr
   assumes one clock and an async reset, active high */
`timescale 1ns/10ps
module pcseq_asserts
  import pcseq_pkg::*;
(
  // --------
  // watched ports
  // --------
  input wire logic                   core_clk_i,
  input wire logic                   rst_i,
  input wire pc_op_t                 pc_op_i,
  input wire logic [JUMP_ADDR_W-1:0] jump_addr_i,
  input wire logic [DATA_W-1:0]      pc_low_wr_data_i,
  input wire logic [DATA_W-1:0]      pc_high_holding_latch_i,
  input wire logic                   indirect_bank_select_i,
  input wire logic [DATA_W-1:0]      indirect_pointer_i,
  input wire logic                   indirect_rd_i,
  input wire logic                   indirect_wr_i,
  input wire logic [DATA_W-1:0]      rf_rd_data_i,
  input wire logic [PC_W-1:0]        fetch_addr_o,
  input wire logic [DATA_W-1:0]      pc_low_byte_o,
  input wire logic [EFF_ADDR_W-1:0]  rf_addr_o,
  input wire logic                   rf_rd_o,
  input wire logic                   rf_wr_o,
  input wire logic [DATA_W-1:0]      indirect_data_port_o
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (rst_i);
  wire logic nz = indirect_pointer_i != 8'h00;
  sequence s_call;
    pc_op_i == PC_OP_CALL;
  endsequence
  chk_step_incr: assert property (pc_op_i == PC_OP_STEP |=>
    fetch_addr_o == $past(fetch_addr_o) + 13'h1) else $error("step");
  chk_page_jump: assert property (pc_op_i inside {PC_OP_CALL, PC_OP_JUMP} |=>
    fetch_addr_o == $past({pc_high_holding_latch_i[4:3], jump_addr_i})) else $error("jump");
  chk_low_load: assert property (pc_op_i == PC_OP_WR_LOW |=>
    fetch_addr_o == $past({pc_high_holding_latch_i[4:0], pc_low_wr_data_i})) else $error("low");
  chk_call_ret: assert property (s_call ##1 pc_op_i == PC_OP_RETURN |=>
    fetch_addr_o == $past(fetch_addr_o, 2) + 13'h1) else $error("return");
  chk_low_mirror: assert property (pc_low_byte_o == fetch_addr_o[7:0]) else $error("mirror");
  chk_eff_addr: assert property (rf_addr_o == {indirect_bank_select_i, indirect_pointer_i})
    else $error("addr");
  chk_self_gate: assert property (rf_rd_o == (indirect_rd_i && nz) &&
    rf_wr_o == (indirect_wr_i && nz)) else $error("gate");
  chk_self_read: assert property (indirect_rd_i && !nz |=>
    indirect_data_port_o == 8'h00) else $error("self read");
  chk_ind_read: assert property (indirect_rd_i && nz |=>
    indirect_data_port_o == $past(rf_rd_data_i)) else $error("read");
endmodule
bind pc_stack_indirect_addr pcseq_asserts chk (.*);

// ### pcseq_pkg.sv
/*
  Shared constants for the program counter, return stack and indirect
  addressing block. Assumes a single core clock and one reset.
*/
package pcseq_pkg;
  localparam int PC_W          = 13;
  localparam int PC_LO_W       = 8;
  localparam int PC_HI_W       = 5;
  localparam int JUMP_ADDR_W   = 11;
  localparam int PAGE_BIT_POS  = 3;
  localparam int STACK_DEPTH   = 8;
  localparam int DATA_W        = 8;
  localparam int EFF_ADDR_W    = 9;
  localparam logic [PC_W-1:0]   PC_RESET     = 13'h0000;
  localparam logic [DATA_W-1:0] INDIRECT_SELF = 8'h00;
  localparam logic [DATA_W-1:0] SELF_READ_VAL = 8'h00;

  typedef enum logic [2:0] {
    PC_OP_STEP   = 3'b000,
    PC_OP_CALL   = 3'b001,
    PC_OP_JUMP   = 3'b010,
    PC_OP_RETURN = 3'b011,
    PC_OP_INTR   = 3'b100,
    PC_OP_WR_LOW = 3'b101,
    PC_OP_HOLD   = 3'b110
  } pc_op_t;
endpackage

// ### return_stack.sv
/*
  Circular return-address stack, no overflow or underflow indication.
  Assumes push and pop are never asked in the same cycle.
*/
`timescale 1ns/10ps
module return_stack #(
  parameter int DEPTH = 8,
  parameter int WIDTH = 13
) (
  // clock and reset
  input  wire logic             core_clk_i,
  input  wire logic             rst_i,
  // stack operations
  input  wire logic             push_i,
  input  wire logic             pop_i,
  input  wire logic [WIDTH-1:0] push_data_i,
  output logic      [WIDTH-1:0] top_o
);
  localparam int PTR_W = $clog2(DEPTH);

  if (DEPTH < 2 || (1 << PTR_W) != DEPTH) begin
    $error("stack depth must be a power of two of at least two");
  end
  if (WIDTH < 1) begin
    $error("stack entries need at least one bit");
  end

  typedef struct packed {
    logic [PTR_W-1:0] ptr;
  } stk_state_t;

  stk_state_t       state_r;
  stk_state_t       state_nxt;
  logic [WIDTH-1:0] mem_r [DEPTH];

  // ----------------------------------------
  // pointer
  // ----------------------------------------
  // pointer wraps silently; a push past depth overwrites the oldest (see RQ7)
  always_comb begin
    state_nxt = state_r;
    if (push_i) begin
      state_nxt.ptr = state_r.ptr + PTR_W'(1);
    end else if (pop_i) begin
      state_nxt.ptr = state_r.ptr - PTR_W'(1);
    end
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_r <= '0;
    end else begin
      state_r <= state_nxt;
    end
  end

  // storage has no reset; content before the first push is undefined anyway
  always_ff @(posedge core_clk_i) begin
    if (push_i) begin
      mem_r[state_r.ptr] <= push_data_i; // see (RQ3)
    end
  end

  assign top_o = mem_r[state_r.ptr - PTR_W'(1)];
endmodule

// ### rf_model.sv
/* register file stand-in, answers reads combinationally
   assumes nine-bit addresses and one clock */
`timescale 1ns/10ps
module rf_model (
  // access
  input  wire logic       core_clk_i,
  input  wire logic [8:0] addr_i,
  input  wire logic       rd_i,
  input  wire logic       wr_i,
  input  wire logic [7:0] wr_data_i,
  output logic      [7:0] rd_data_o
);
  logic [7:0] mem [512];
  logic [7:0] last_r;
  // idle lines show inverted data so a stale copy never passes
  assign rd_data_o = rd_i ? mem[addr_i] : ~last_r;
  initial begin
    last_r = 8'h00;
    for (int i = 0; i < 512; i++) mem[i] = 8'(i) ^ 8'hA5;
  end
  always @(posedge core_clk_i) begin
    if (wr_i) mem[addr_i] <= wr_data_i;
    if (rd_i) last_r <= mem[addr_i];
  end
endmodule
